/* design/psc_pkg.sv */
// Package for the PHY status, counter and management-pin register bank.
// Assumes an AHB-Lite master with 32-bit single word transfers.
package psc_pkg;
  // Printed offsets are not all word multiples: kept as indices.
  localparam logic [7:0] IDX_PARTNER_ABILITY = 8'h68;
  localparam logic [7:0] IDX_EXPANSION = 8'h6a;
  localparam logic [7:0] IDX_DISCONNECT = 8'h6c;
  localparam logic [7:0] IDX_FALSE_CARRIER = 8'h6e;
  localparam logic [7:0] IDX_TEST_CTRL = 8'h70;
  localparam logic [7:0] IDX_RX_ERROR = 8'h72;
  localparam logic [7:0] IDX_XCVR_CONFIG = 8'h74;
  localparam logic [7:0] IDX_MGMT_PORT = 8'h82;
  localparam int ADDR_LSB = 2;
  // Test control fields
  localparam int TST_LOOPBACK_BIT = 7;
  localparam int TST_LED_PULSE_BIT = 3;
  // Transceiver configuration fields
  localparam int CFG_FAST_TIMER_BIT = 15;
  localparam int CFG_LINK_DIS_N_BIT = 9;
  localparam int CFG_HEARTBEAT_BIT = 8;
  localparam int CFG_JABBER_BIT = 7;
  localparam int CFG_FORCE_LINK_N_BIT = 6;
  localparam int CFG_DISC_BYPASS_BIT = 5;
  localparam int CFG_CON_STATUS_BIT = 3;
  localparam int CFG_CON_LED_BIT = 2;
  localparam int CFG_SCRAMBLER_BIT = 0;
  // Management port fields
  localparam int MP_DIR_BIT = 7;
  localparam int MP_DOUT_BIT = 2;
  localparam int MP_DIN_BIT = 1;
  localparam int MP_CLK_BIT = 0;
  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h03c0;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // Status and event inputs from the transceiver core
  typedef struct packed {
    logic multi_link_fault;
    logic partner_next_page_capable;
    logic local_next_page_capable;
    logic page_received;
    logic partner_autoneg_capable;
    logic ability_detect;
    logic parallel_fault;
    logic link_check;
    logic connected;
    logic link_pulse;
    logic disconnect_event;
    logic false_carrier_event;
    logic receive_error_event;
  } psc_phy_status_type;

  // Controls steering the transceiver core
  typedef struct packed {
    logic autoneg_loopback;
    logic fast_timers;
    logic link_disable_n;
    logic heartbeat_enable;
    logic jabber_protect_enable;
    logic force_link_100_n;
    logic disconnect_bypass;
    logic scrambler_bypass;
  } psc_phy_ctrl_type;
endpackage : psc_pkg

/* design/psc_regs.sv */
// Register bank: expansion status, clear-on-read counters, test and
// transceiver controls, and the bit-bang management pin port.
// Assumes status inputs are on core_clk_in; the data pin passes a synchroniser.
// Functional notes
// - Expansion bits 15..5 read zero
// - Bit 4 shows multiple link fault
// - Bit 3 shows partner next-page support
// - Bit 2 shows local next-page ability
// - Bit 1 page received, cleared by ability read
// - Bit 0 shows partner auto-negotiation support
// - Disconnect counter wraps, clears on read
// - False-carrier counter clears on read
// - Receive-error counter clears on read
// - Test bit 7 sets auto-negotiation loopback
// - Test bit 3 makes first LED pulses
// - Test bits 2..0 record visited states
// - Config bit 15 write-only fast timers
// - Config bit 9 active-low link disable
// - Config bit 8 heartbeat, 10 Mb/s only
// - Config bit 7 jabber protection enable
// - Config bit 6 low forces 100M link
// - Config bit 5 bypasses disconnect detection
// - Config bit 3 status, bit 2 LED
// - Port bit 7 sets data pin direction
// - Port bit 2 drives, bit 1 samples
// - Port bit 0 drives management clock
// - Partner ability register read-only at 0x68
//
// Added by the designer: the AHB-Lite register port.
module psc_regs (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire psc_pkg::psc_phy_status_type phy_status_in,
  input wire logic [15:0] partner_ability_in,
  input wire logic normal_first_led_in,
  input wire logic normal_second_led_in,
  output psc_pkg::psc_phy_ctrl_type phy_ctrl_out,
  output logic first_led_output_out,
  output logic second_led_output_out,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_n_out,
  input wire logic mdio_in
);
  // Address phase capture
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] rd_idx;
  logic rd_take;
  localparam int ADDR_LSB_W = psc_pkg::ADDR_LSB;
  assign rd_idx = haddr_in[ADDR_LSB_W+7:ADDR_LSB_W];
  assign rd_take = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  logic wr_take;
  assign wr_take = hsel_in && hready_in && htrans_in[1] && hwrite_in;

  logic wr_test;
  logic wr_cfg;
  logic wr_port;
  assign wr_test = wr_pend_reg && wr_idx_reg == psc_pkg::IDX_TEST_CTRL;
  assign wr_cfg = wr_pend_reg && wr_idx_reg == psc_pkg::IDX_XCVR_CONFIG;
  assign wr_port = wr_pend_reg && wr_idx_reg == psc_pkg::IDX_MGMT_PORT;

  // Read-side effects take place on the address phase
  logic rd_disc;
  logic rd_fc;
  logic rd_rxe;
  logic rd_ability;
  assign rd_disc = rd_take && rd_idx == psc_pkg::IDX_DISCONNECT;
  assign rd_fc = rd_take && rd_idx == psc_pkg::IDX_FALSE_CARRIER;
  assign rd_rxe = rd_take && rd_idx == psc_pkg::IDX_RX_ERROR;
  assign rd_ability = rd_take && rd_idx == psc_pkg::IDX_PARTNER_ABILITY;

  // Synchronise the management data pin
  logic mdio_s1_reg;
  logic mdio_s2_reg;
  always_ff @(posedge core_clk_in) begin
    mdio_s1_reg <= mdio_in;
    mdio_s2_reg <= mdio_s1_reg;
  end

  // Sticky and control state
  logic page_rx_reg;
  logic [2:0] seen_reg;
  logic loopback_reg;
  logic led_pulse_sel_reg;
  logic [15:0] cfg_reg;
  logic mp_dir_reg;
  logic mp_dout_reg;
  logic mp_clk_reg;
  logic [15:0] disc_cnt_reg;
  logic [15:0] fc_cnt_reg;
  logic [15:0] rxe_cnt_reg;

  // Counter step; an event in the read cycle starts the fresh count
  function automatic logic [15:0] cnt_next(input logic [15:0] cur,
                                            input logic clr,
                                            input logic ev);
    logic [15:0] base;
    base = clr ? psc_pkg::CNT_RESET : cur;
    cnt_next = ev ? 16'(base + 16'h0001) : base;
  endfunction : cnt_next

  logic disc_ev;
  assign disc_ev = phy_status_in.disconnect_event &&
                   !cfg_reg[psc_pkg::CFG_DISC_BYPASS_BIT];

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      disc_cnt_reg <= psc_pkg::CNT_RESET;
      fc_cnt_reg <= psc_pkg::CNT_RESET;
      rxe_cnt_reg <= psc_pkg::CNT_RESET;
    end else begin
      disc_cnt_reg <= cnt_next(disc_cnt_reg, rd_disc, disc_ev);
      fc_cnt_reg <= cnt_next(fc_cnt_reg, rd_fc,
                             phy_status_in.false_carrier_event);
      rxe_cnt_reg <= cnt_next(rxe_cnt_reg, rd_rxe,
                              phy_status_in.receive_error_event);
    end
  end

  // Set wins over the clear on page received
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      page_rx_reg <= 1'b0;
      seen_reg <= 3'h0;
    end else begin
      page_rx_reg <= phy_status_in.page_received ||
                     (page_rx_reg && !rd_ability);
      seen_reg <= seen_reg | {phy_status_in.ability_detect,
                              phy_status_in.parallel_fault,
                              phy_status_in.link_check};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      loopback_reg <= 1'b0;
      led_pulse_sel_reg <= 1'b0;
    end else if (wr_test) begin
      loopback_reg <= hwdata_in[psc_pkg::TST_LOOPBACK_BIT];
      led_pulse_sel_reg <= hwdata_in[psc_pkg::TST_LED_PULSE_BIT];
    end
  end

  // Writable configuration bits; status bit 3 is never stored
  localparam logic [15:0] CFG_WMASK = 16'h83e5;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cfg_reg <= psc_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= hwdata_in[15:0] & CFG_WMASK;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      mp_dir_reg <= 1'b0;
      mp_dout_reg <= 1'b0;
      mp_clk_reg <= 1'b0;
    end else if (wr_port) begin
      mp_dir_reg <= hwdata_in[psc_pkg::MP_DIR_BIT];
      mp_dout_reg <= hwdata_in[psc_pkg::MP_DOUT_BIT];
      mp_clk_reg <= hwdata_in[psc_pkg::MP_CLK_BIT];
    end
  end

  // Read data mux
  logic [15:0] exp_word;
  logic [15:0] test_word;
  logic [15:0] cfg_word;
  logic [15:0] port_word;
  logic [15:0] rd_word;
  assign exp_word = {11'h000,
                     phy_status_in.multi_link_fault,
                     phy_status_in.partner_next_page_capable,
                     phy_status_in.local_next_page_capable,
                     page_rx_reg,
                     phy_status_in.partner_autoneg_capable};
  assign test_word = {8'h00, loopback_reg, 3'h0, led_pulse_sel_reg,
                      seen_reg};
  // Fast-timer bit reads zero, it is write-only
  assign cfg_word = {1'b0, cfg_reg[14:4], phy_status_in.connected,
                     cfg_reg[2:0]};
  assign port_word = {8'h00, mp_dir_reg, 4'h0, mp_dout_reg, mdio_s2_reg,
                      mp_clk_reg};
  assign rd_word =
    (rd_idx == psc_pkg::IDX_EXPANSION) ? exp_word :
    (rd_idx == psc_pkg::IDX_DISCONNECT) ? disc_cnt_reg :
    (rd_idx == psc_pkg::IDX_FALSE_CARRIER) ? fc_cnt_reg :
    (rd_idx == psc_pkg::IDX_TEST_CTRL) ? test_word :
    (rd_idx == psc_pkg::IDX_RX_ERROR) ? rxe_cnt_reg :
    (rd_idx == psc_pkg::IDX_XCVR_CONFIG) ? cfg_word :
    (rd_idx == psc_pkg::IDX_MGMT_PORT) ? port_word :
    (rd_idx == psc_pkg::IDX_PARTNER_ABILITY) ? partner_ability_in :
    16'h0000;

  // Zero-wait slave; unmapped reads return zero, writes are dropped
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_idx_reg <= rd_idx;
      end
      if (rd_take) begin
        hrdata_out <= {16'h0000, rd_word};
      end
    end
  end

  // Registered outputs
  logic first_led_src;
  logic second_led_src;
  assign first_led_src = led_pulse_sel_reg ? phy_status_in.link_pulse
                                           : normal_first_led_in;
  assign second_led_src = cfg_reg[psc_pkg::CFG_CON_LED_BIT] ?
                          phy_status_in.connected
                          : normal_second_led_in;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      first_led_output_out <= 1'b0;
      second_led_output_out <= 1'b0;
      mdc_out <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe_n_out <= 1'b1;
      phy_ctrl_out <= '0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      first_led_output_out <= first_led_src;
      second_led_output_out <= second_led_src;
      mdc_out <= mp_clk_reg;
      mdio_out <= mp_dout_reg;
      mdio_oe_n_out <= !mp_dir_reg;
      phy_ctrl_out.autoneg_loopback <= loopback_reg;
      phy_ctrl_out.fast_timers <= cfg_reg[psc_pkg::CFG_FAST_TIMER_BIT];
      phy_ctrl_out.link_disable_n <= cfg_reg[psc_pkg::CFG_LINK_DIS_N_BIT];
      phy_ctrl_out.heartbeat_enable <=
        cfg_reg[psc_pkg::CFG_HEARTBEAT_BIT];
      phy_ctrl_out.jabber_protect_enable <= cfg_reg[psc_pkg::CFG_JABBER_BIT];
      phy_ctrl_out.force_link_100_n <=
        cfg_reg[psc_pkg::CFG_FORCE_LINK_N_BIT];
      phy_ctrl_out.disconnect_bypass <= cfg_reg[psc_pkg::CFG_DISC_BYPASS_BIT];
      phy_ctrl_out.scrambler_bypass <= cfg_reg[psc_pkg::CFG_SCRAMBLER_BIT];
    end
  end
endmodule : psc_regs

/* dv/psc_mgmt_partner.sv */
// Far-side transceiver model on the management pins.
// Assumes the host owns the data line while its enable is low.
module psc_mgmt_partner #(parameter logic [15:0] REPLY = 16'hc5a3) (
  input wire logic mdc_in,
  input wire logic mdio_drv_in,
  input wire logic mdio_oe_n_in,
  output logic mdio_line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] shift_reg = REPLY;
  // New reply bit each clock, so a stale sample shows
  always @(posedge mdc_in) shift_reg <= {shift_reg[14:0], shift_reg[15]};
  assign mdio_line_out = mdio_oe_n_in ? shift_reg[15] : mdio_drv_in;
endmodule : psc_mgmt_partner

/* dv/psc_regs_assertions.sv */
// Port checker for the register bank.
// Assumes hready_in is fed from hreadyout_out.
module psc_regs_assertions (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire psc_pkg::psc_phy_status_type phy_status_in,
  input wire logic mdc_out,
  input wire logic mdio_out,
  input wire logic mdio_oe_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  logic rd_reg;
  logic wr_reg;
  logic [31:0] adr_reg;
  wire take_now = hsel_in && hready_in && htrans_in[1];
  wire exp_rd = rd_reg && adr_reg == 32'h1a8;
  wire cfg_rd = rd_reg && adr_reg == 32'h1d0;
  wire prt_wr = wr_reg && adr_reg == 32'h208;
  // Data phase trackers
  always_ff @(posedge core_clk_in) begin
    rd_reg <= rstn_in && take_now && !hwrite_in;
    wr_reg <= rstn_in && take_now && hwrite_in;
    adr_reg <= haddr_in;
  end
  property p_rsv;
    exp_rd |-> hrdata_out[31:5] == 27'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("expansion reserved bits set");
  property p_fault;
    exp_rd |-> hrdata_out[4] == $past(phy_status_in.multi_link_fault);
  endproperty
  a_fault: assert property (p_fault)
    else $error("link fault bit wrong");
  property p_pnp;
    exp_rd |->
      hrdata_out[3] == $past(phy_status_in.partner_next_page_capable);
  endproperty
  a_pnp: assert property (p_pnp)
    else $error("partner next page bit wrong");
  property p_lnp;
    exp_rd |->
      hrdata_out[2] == $past(phy_status_in.local_next_page_capable);
  endproperty
  a_lnp: assert property (p_lnp)
    else $error("local next page bit wrong");
  property p_pan;
    exp_rd |->
      hrdata_out[0] == $past(phy_status_in.partner_autoneg_capable);
  endproperty
  a_pan: assert property (p_pan)
    else $error("partner autoneg bit wrong");
  property p_con;
    cfg_rd |-> hrdata_out[3] == $past(phy_status_in.connected);
  endproperty
  a_con: assert property (p_con)
    else $error("connection status bit wrong");
  property p_dir;
    prt_wr |=> ##1 mdio_oe_n_out == !$past(hwdata_in[7], 2);
  endproperty
  a_dir: assert property (p_dir)
    else $error("data pin direction wrong");
  property p_dout;
    prt_wr |=> ##1 mdio_out == $past(hwdata_in[2], 2);
  endproperty
  a_dout: assert property (p_dout)
    else $error("data pin level wrong");
  property p_mdc;
    prt_wr |=> ##1 mdc_out == $past(hwdata_in[0], 2);
  endproperty
  a_mdc: assert property (p_mdc)
    else $error("management clock wrong");
endmodule : psc_regs_assertions
bind psc_regs psc_regs_assertions chk_u (.core_clk_in(core_clk_in),
  .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out),
  .phy_status_in(phy_status_in), .mdc_out(mdc_out), .mdio_out(mdio_out),
  .mdio_oe_n_out(mdio_oe_n_out));

/* dv/test_phy_status_counter_mgmt_regs.sv */
// Self-checking bench for the status, counter and management registers.
// Assumes a single slave, so hreadyout feeds hready back.
module test_phy_status_counter_mgmt_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdp = 1'h0;
  logic nled = 1'h0, hrdy, hresp, mdc, mdat, oe_n, fled, sled, line, b;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [15:0] abil = 16'h0;
  logic [31:0] cadr [3] = '{32'h1c8, 32'h1b8, 32'h1b0};
  logic [31:0] q [$];
  psc_pkg::psc_phy_status_type st = '0;
  psc_pkg::psc_phy_ctrl_type ctrl;
  int n_mismatch = 0, n_compared = 0, seed = 32'h22a7, n;
  psc_regs dut_u (.core_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .phy_status_in(st), .partner_ability_in(abil),
    .normal_first_led_in(nled), .normal_second_led_in(!st.connected),
    .phy_ctrl_out(ctrl), .first_led_output_out(fled),
    .second_led_output_out(sled), .mdc_out(mdc), .mdio_out(mdat),
    .mdio_oe_n_out(oe_n), .mdio_in(line));
  psc_mgmt_partner far_u (.mdc_in(mdc), .mdio_drv_in(mdat),
    .mdio_oe_n_in(oe_n), .mdio_line_out(line));
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic xf(input logic w, input logic [31:0] a, d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
  endtask : xf
  task automatic rd(input logic [31:0] a, exp);
    q.push_back(exp);
    xf(1'h0, a, 32'h0);
  endtask : rd
  // Extra edges let registered outputs land
  task automatic wr(input logic [31:0] a, d);
    xf(1'h1, a, d);
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic pulse(input int k, input int cnt);
    repeat (cnt) begin
      st[k] <= 1'h1;
      @(posedge clk);
    end
    st[k] <= 1'h0;
    @(posedge clk);
  endtask : pulse
  // Read results are checked against the oldest queued note
  always @(posedge clk) begin
    if (rdp && hrdy) chk(hrdata, q.pop_front());
    if (rdp) chk({hrdy, hresp}, 32'h2);
    rdp <= hsel && htrans[1] && !hwrite && hrdy;
  end
  initial forever #50 clk = ~clk;
  initial begin
    #8000000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rd(32'h1d0, 32'h3c0);
    chk(ctrl, 8'h3c);
    for (int a = 32'h1b0; a <= 32'h1c8; a += 8) rd(a, 32'h0);
    rd(32'h100, 32'h0);
    v = $random(seed);
    st[12:8] <= v[4:0] & 5'h1d;
    rd(32'h1a8, {27'h0, v[4:0] & 5'h1d});
    pulse(9, 1);
    abil <= v[31:16];
    rd(32'h1a8, {27'h0, v[4:0] & 5'h1d | 5'h2});
    wr(32'h1a0, 32'hffff);
    rd(32'h1a0, {16'h0, v[31:16]});
    rd(32'h1a8, {27'h0, v[4:0] & 5'h1d});
    for (int k = 0; k < 3; k++) begin
      n = (k == 2) ? 65537 : 3 + ($random(seed) & 7);
      pulse(k, n);
      rd(cadr[k], n & 32'hffff);
      rd(cadr[k], 32'h0);
    end
    wr(32'h1d0, 32'h20);
    pulse(2, 4);
    rd(32'h1b0, 32'h0);
    v = $random(seed);
    st[4] <= 1'h1;
    wr(32'h1d0, v | 32'h4);
    rd(32'h1d0, (v & 32'h3e1) | 32'hc);
    chk(ctrl, {1'h0, v[15], v[9:5], v[0]});
    chk(sled, 1'h1);
    wr(32'h1c0, 32'h8f);
    rd(32'h1c0, 32'h88);
    for (int k = 5; k < 8; k++) pulse(k, 1);
    rd(32'h1c0, 32'h8f);
    chk(ctrl[7], 1'h1);
    st[3] <= v[0];
    nled <= ~v[0];
    repeat (3) @(posedge clk);
    chk(fled, v[0]);
    for (int i = 0; i < 8; i++) begin
      b = v[i];
      wr(32'h208, {24'h0, 1'h1, 4'h0, b, 2'h0});
      chk({mdc, mdat, oe_n}, {1'h0, b, 1'h0});
      wr(32'h208, {24'h0, 1'h1, 4'h0, b, 2'h1});
      chk(mdc, 1'h1);
    end
    for (int i = 0; i < 4; i++) begin
      wr(32'h208, {31'h0, i[0]});
      repeat (2) @(posedge clk);
      rd(32'h208, {30'h0, line, i[0]});
    end
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : test_phy_status_counter_mgmt_regs
